// ==== verilog/chg_map.svh ====
/*
 Constants for the charger host: target address, bit timing, interrupt timing
 and the line drive encodings. Assumes a 250 MHz system clock.
*/
// Overview of operation
// (R1) Target answers only at address 0x74
// (R2) Standard 100k and fast 400k rates
// (R3) Lines driven low or released only
// (R4) SDA changes only while SCL low
// (R5) Start and stop are SDA edges, SCL high
// (R6) Only master makes start and stop
// (R7) Eight bits, MSB first, then acknowledge
// (R8) Target may stretch SCL low
// (R9) Transmitter releases SDA on ninth clock
// (R10) NACK is followed by stop or restart
// (R11) First byte: address plus direction bit
// (R12) Repeated start keeps bus, else stop
// (R13) Unknown register address gets NACK
// (R14) Burst bytes go to consecutive registers
// (R15) Flag changes give 1 ms interrupt pulse
// (R16) Load insert flags pulse on rise only
// (R17) Bus short holds interrupt continuously active
// (R18) Load insert flags clear when read
// (R19) Mask bit silences interrupt, status updates
// (R20) Drive field: 00 float, 01 source
// (R21) Voltage field: 10 2.75V, 01 1.2V
// (R22) Short bit joins lines when one
// (R23) Write: addr, reg, data; read via restart
// (R24) Interrupt active low, pulse timer restarts
`ifndef CHG_MAP_SVH
`define CHG_MAP_SVH

// Target address and direction bits
`define DEV_ADDR 7'h74
`define DIR_WR 1'h0
`define DIR_RD 1'h1

// Bit timing, ns; quarter bit rounds up so rates never exceed the limit
`define CLK_NS 4
`define STD_BIT_NS 10000
`define FAST_BIT_NS 2500
`define Q_STD ((`STD_BIT_NS + 4 * `CLK_NS - 1) / (4 * `CLK_NS))
`define Q_FAST ((`FAST_BIT_NS + 4 * `CLK_NS - 1) / (4 * `CLK_NS))
`define Q_W 10

// Interrupt timing, us; low longer than this means a held alert
`define INT_PULSE_US 1000
`define INT_LONG_US 1500
`define INT_LONG_CYC (`INT_LONG_US * 1000 / `CLK_NS)
`define INT_CNT_W 20

// Line drive encodings written by software
`define LINE_FLOAT 2'h0
`define LINE_SOURCE 2'h1
`define VSEL_2V75 2'h2
`define VSEL_1V2 2'h1
`define LINES_JOINED 1'h1
`define LINES_APART 1'h0

`endif

// ==== verilog/chg_pkg.sv ====
/*
 Types shared by the charger host modules.
 Assumes chg_map.svh is on the include path.
*/
`default_nettype none
`include "chg_map.svh"
package chg_pkg;
	typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} bit_cmd_t;
	typedef enum logic {E_IDLE, E_RUN} eng_st_t;
	typedef enum logic [2:0] {M_IDLE, M_START, M_LOAD, M_TXBIT, M_RXACK, M_RXBIT, M_TXACK, M_STOP} mst_st_t;
	typedef enum logic [2:0] {P_ADDR_W, P_REG, P_DATA_W, P_ADDR_R, P_DATA_R} phase_t;

	typedef struct packed {
		eng_st_t st;
		logic [1:0] ph;
		logic [`Q_W-1:0] cnt;
		bit_cmd_t cmd;
		logic wbit;
		logic rbit;
		logic done;
		logic scl_rel;
		logic sda_rel;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl_v;
		logic sda_v;
	} eng_t;

	typedef struct packed {
		mst_st_t st;
		phase_t ph;
		logic pend;
		logic wr;
		logic [7:0] reg_a;
		logic [7:0] sh;
		logic [2:0] bit_n;
		logic [7:0] left;
		logic [7:0] rdata;
		logic rvalid;
		logic xdone;
		logic nack;
		logic [2:0] int_s;
		logic int_v;
		logic [`INT_CNT_W-1:0] low_cnt;
		logic int_evt;
		logic short_on;
	} mst_t;
endpackage : chg_pkg
`default_nettype wire

// ==== verilog/bit_if.sv ====
/*
 Carrier between the transfer sequencer and the bit engine.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface bit_if import chg_pkg::*;;
	logic cmd_valid;
	logic cmd_ready;
	bit_cmd_t cmd;
	logic wbit;
	logic rbit;
	logic done;
	logic fast;
	logic scl_in;
	logic sda_in;
	logic scl_oe;
	logic sda_oe;
	modport ctl (output cmd_valid, cmd, wbit, fast, scl_in, sda_in, input cmd_ready, rbit, done, scl_oe, sda_oe);
	modport eng (input cmd_valid, cmd, wbit, fast, scl_in, sda_in, output cmd_ready, rbit, done, scl_oe, sda_oe);
endinterface : bit_if
`default_nettype wire

// ==== verilog/bit_engine.sv ====
/*
 Bit engine: makes one start, stop, write bit or read bit as four quarter
 phases, generating SCL from clk. Assumes open-drain pins with pull-ups.
*/
`timescale 1ns/1ns
`default_nettype none
module bit_engine import chg_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	bit_if.eng bif
);
	eng_t r;
	eng_t n;

	// Released levels {scl, sda} for each command and phase
	function automatic logic [1:0] pins(bit_cmd_t c, logic [1:0] p, logic b);
		logic hi;
		hi = (p == 2'h1) || (p == 2'h2);
		case (c)
			CMD_START: pins = (p == 2'h0) ? 2'h1 : (p == 2'h1) ? 2'h3 : (p == 2'h2) ? 2'h2 : 2'h0;
			CMD_STOP: pins = (p == 2'h0) ? 2'h0 : (p == 2'h1) ? 2'h2 : 2'h3;
			CMD_WRITE: pins = {hi, b};
			default: pins = {hi, 1'h1};
		endcase
	endfunction : pins

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		logic [`Q_W-1:0] q;
		// (R2) quarter length per bit rate
		q = bif.fast ? `Q_W'(`Q_FAST) : `Q_W'(`Q_STD);
		n = r;
		n.done = 1'h0;
		// Three-stage pin sync; a level counts once stages two and three agree
		n.scl_s = {r.scl_s[1:0], bif.scl_in};
		n.sda_s = {r.sda_s[1:0], bif.sda_in};
		if (r.scl_s[1] == r.scl_s[2]) begin
			n.scl_v = r.scl_s[2];
		end
		if (r.sda_s[1] == r.sda_s[2]) begin
			n.sda_v = r.sda_s[2];
		end
		case (r.st)
			E_IDLE: begin
				if (bif.cmd_valid) begin
					n.st = E_RUN;
					n.cmd = bif.cmd;
					n.wbit = bif.wbit;
					n.ph = 2'h0;
					n.cnt = '0;
					{n.scl_rel, n.sda_rel} = pins(bif.cmd, 2'h0, bif.wbit);
				end
			end
			E_RUN: begin
				// (R8) hold timing while target stretches
				if (r.scl_rel && !r.scl_v) begin
					n.cnt = r.cnt;
				end else if (r.cnt == q - `Q_W'(1)) begin
					n.cnt = '0;
					// (R9) sample ack with SCL high
					if (r.ph == 2'h2 && r.cmd == CMD_READ) begin
						n.rbit = r.sda_v;
					end
					if (r.ph == 2'h3) begin
						n.st = E_IDLE;
						n.done = 1'h1;
					end else begin
						n.ph = r.ph + 2'h1;
						// (R4) write and read bits keep SDA fixed across phases; only start and stop move it, with SCL high
						{n.scl_rel, n.sda_rel} = pins(r.cmd, r.ph + 2'h1, r.wbit);
					end
				end else begin
					n.cnt = r.cnt + `Q_W'(1);
				end
			end
			default: n.st = E_IDLE;
		endcase
	end

	// Registered state; both lines released in reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			r <= '0;
			r.scl_rel <= 1'h1;
			r.sda_rel <= 1'h1;
			r.scl_s <= 3'h7;
			r.sda_s <= 3'h7;
			r.scl_v <= 1'h1;
			r.sda_v <= 1'h1;
		end else begin
			r <= n;
		end
	end

	// (R3) pins only pulled low or released
	assign bif.scl_oe = !r.scl_rel;
	assign bif.sda_oe = !r.sda_rel;
	assign bif.cmd_ready = (r.st == E_IDLE);
	assign bif.done = r.done;
	assign bif.rbit = r.rbit;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_enter2;
		r.st == E_RUN && r.ph == 2'h2 && $past(r.ph) == 2'h1;
	endsequence

	AST_START_EDGE: assert property ((s_enter2 and r.cmd == CMD_START) |-> $past(r.sda_rel) && !r.sda_rel && r.scl_rel) // (R5)
		else $error("start edge wrong");
	AST_STOP_EDGE: assert property ((s_enter2 and r.cmd == CMD_STOP) |-> !$past(r.sda_rel) && r.sda_rel && r.scl_rel) // (R5)
		else $error("stop edge wrong");
	AST_SDA_STABLE: assert property ((r.st == E_RUN && r.ph == 2'h2 && (r.cmd == CMD_WRITE || r.cmd == CMD_READ)) |-> $stable(r.sda_rel)) // (R4)
		else $error("sda moved while scl high");
	AST_READ_RELEASE: assert property ((r.st == E_RUN && r.cmd == CMD_READ) |-> r.sda_rel) // (R9)
		else $error("sda driven during read");
	AST_STRETCH: assert property ((r.st == E_RUN && r.scl_rel && !r.scl_v) |=> r.cnt == $past(r.cnt) && r.ph == $past(r.ph)) // (R8)
		else $error("timing ran while scl held low");
endmodule : bit_engine
`default_nettype wire

// ==== verilog/charger_host.sv ====
/*
 Charger host: two-wire bus master that writes and reads the charger's
 registers in single or burst form, and watches its interrupt pin.
 Assumes external pull-ups on SCL, SDA and the interrupt line.
*/
`timescale 1ns/1ns
`default_nettype none
`include "chg_map.svh"
module charger_host import chg_pkg::*; #(
	parameter logic [`INT_CNT_W-1:0] INT_LONG_CYC = `INT_CNT_W'(`INT_LONG_CYC)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fast_mode,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [7:0] req_reg,
	input wire logic [7:0] req_len,
	input wire logic [7:0] wdata,
	input wire logic wdata_valid,
	output logic wdata_ready,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic xfer_done,
	output logic xfer_nack,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic int_n_in,
	output logic int_event,
	output logic short_alert
);
	mst_t r;
	mst_t n;
	logic bit_state;
	bit_if bif ();

	// -----------------------------------------------------------------
	// Bit engine
	// -----------------------------------------------------------------
	bit_engine u_eng (
		.clk(clk),
		.resetn(resetn),
		.bif(bif)
	);

	assign bif.fast = fast_mode;
	assign bif.scl_in = scl_in;
	assign bif.sda_in = sda_in;

	// (R3) open-drain: output level always low
	assign scl_out = 1'h0;
	assign sda_out = 1'h0;
	assign scl_oe = bif.scl_oe;
	assign sda_oe = bif.sda_oe;

	// Command to the engine follows the sequencer state
	assign bit_state = (r.st != M_IDLE) && (r.st != M_LOAD);
	assign bif.cmd_valid = bit_state && !r.pend;
	always_comb begin
		bif.cmd = CMD_WRITE;
		bif.wbit = r.sh[7];
		case (r.st)
			// (R6) master alone issues start and stop
			M_START: bif.cmd = CMD_START;
			M_STOP: bif.cmd = CMD_STOP;
			M_RXACK: bif.cmd = CMD_READ;
			M_RXBIT: bif.cmd = CMD_READ;
			// (R14) ack every read byte but the last
			M_TXACK: bif.wbit = (r.left == 8'h1);
			default: bif.cmd = CMD_WRITE;
		endcase
	end

	// -----------------------------------------------------------------
	// Next state: sequencer and interrupt watch
	// -----------------------------------------------------------------
	always_comb begin
		n = r;
		n.rvalid = 1'h0;
		n.xdone = 1'h0;
		n.int_evt = 1'h0;

		// Interrupt pin sync, three stages
		n.int_s = {r.int_s[1:0], int_n_in};
		if (r.int_s[1] == r.int_s[2]) begin
			n.int_v = r.int_s[2];
		end
		// (R24) pin is active low
		if (!r.int_v) begin
			// (R17) long low is a held alert
			if (r.low_cnt != INT_LONG_CYC) begin
				n.low_cnt = r.low_cnt + `INT_CNT_W'(1);
			end else begin
				n.short_on = 1'h1;
			end
		end else begin
			n.low_cnt = '0;
			n.short_on = 1'h0;
			// (R15) end of a pulse means a flag changed
			if (r.low_cnt != '0 && r.low_cnt != INT_LONG_CYC) begin
				n.int_evt = 1'h1;
			end
		end

		// Engine handshake bookkeeping
		if (bif.cmd_valid && bif.cmd_ready) begin
			n.pend = 1'h1;
		end
		if (bif.done) begin
			n.pend = 1'h0;
		end

		case (r.st)
			M_IDLE: begin
				if (req_valid) begin
					n.st = M_START;
					n.ph = P_ADDR_W;
					n.wr = req_write;
					n.reg_a = req_reg;
					n.left = (req_len == 8'h0) ? 8'h1 : req_len;
					n.nack = 1'h0;
				end
			end
			M_START: begin
				if (bif.done) begin
					n.st = M_LOAD;
				end
			end
			M_LOAD: begin
				n.bit_n = 3'h7;
				n.st = M_TXBIT;
				case (r.ph)
					// (R1) write address byte
					// (R11) address then direction bit
					P_ADDR_W: n.sh = {`DEV_ADDR, `DIR_WR};
					P_REG: n.sh = r.reg_a;
					P_ADDR_R: n.sh = {`DEV_ADDR, `DIR_RD};
					P_DATA_R: n.st = M_RXBIT;
					default: begin
						// Data byte waits for the user; bus holds SCL low meanwhile
						if (wdata_valid) begin
							n.sh = wdata;
						end else begin
							n.st = M_LOAD;
						end
					end
				endcase
			end
			M_TXBIT: begin
				// (R7) eight bits MSB first
				if (bif.done) begin
					n.sh = {r.sh[6:0], 1'h0};
					n.bit_n = r.bit_n - 3'h1;
					if (r.bit_n == 3'h0) begin
						n.st = M_RXACK;
					end
				end
			end
			M_RXACK: begin
				if (bif.done) begin
					// (R10) stop after NACK
					// (R13) bad register is refused, end transfer
					if (bif.rbit) begin
						n.nack = 1'h1;
						n.st = M_STOP;
					end else begin
						n.st = M_LOAD;
						case (r.ph)
							P_ADDR_W: n.ph = P_REG;
							P_REG: begin
								// (R23) reads turn round via restart
								// (R12) restart keeps the bus
								if (r.wr) begin
									n.ph = P_DATA_W;
								end else begin
									n.ph = P_ADDR_R;
									n.st = M_START;
								end
							end
							P_ADDR_R: n.ph = P_DATA_R;
							default: begin
								// (R14) burst continues to next register
								if (r.left == 8'h1) begin
									n.st = M_STOP;
								end else begin
									n.left = r.left - 8'h1;
								end
							end
						endcase
					end
				end
			end
			M_RXBIT: begin
				if (bif.done) begin
					n.sh = {r.sh[6:0], bif.rbit};
					n.bit_n = r.bit_n - 3'h1;
					if (r.bit_n == 3'h0) begin
						n.rdata = {r.sh[6:0], bif.rbit};
						n.rvalid = 1'h1;
						n.st = M_TXACK;
					end
				end
			end
			M_TXACK: begin
				if (bif.done) begin
					if (r.left == 8'h1) begin
						n.st = M_STOP;
					end else begin
						n.left = r.left - 8'h1;
						n.st = M_LOAD;
					end
				end
			end
			M_STOP: begin
				if (bif.done) begin
					n.st = M_IDLE;
					n.xdone = 1'h1;
				end
			end
			default: n.st = M_IDLE;
		endcase
	end

	// Registered state; sync stages idle high
	always_ff @(posedge clk) begin
		if (!resetn) begin
			r <= '0;
			r.int_s <= 3'h7;
			r.int_v <= 1'h1;
		end else begin
			r <= n;
		end
	end

	// -----------------------------------------------------------------
	// User side outputs
	// -----------------------------------------------------------------
	assign req_ready = (r.st == M_IDLE);
	assign wdata_ready = (r.st == M_LOAD) && (r.ph == P_DATA_W);
	assign rdata = r.rdata;
	assign rdata_valid = r.rvalid;
	assign xfer_done = r.xdone;
	assign xfer_nack = r.nack;
	assign int_event = r.int_evt;
	assign short_alert = r.short_on;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_ack_done;
		r.st == M_RXACK && bif.done;
	endsequence
	sequence s_addr_load;
		r.st == M_LOAD && (r.ph == P_ADDR_W || r.ph == P_ADDR_R);
	endsequence

	AST_ADDR_BYTE: assert property (s_addr_load |=> r.sh == {`DEV_ADDR, (r.ph == P_ADDR_R)} && r.st == M_TXBIT) // (R1)
		else $error("address byte wrong");
	AST_BYTE_LEN: assert property ((r.st == M_RXACK && $past(r.st) == M_TXBIT) |-> $past(r.bit_n) == 3'h0) // (R7)
		else $error("byte not eight bits");
	AST_NACK_STOP: assert property ((s_ack_done and bif.rbit) |=> r.st == M_STOP && r.nack) // (R10)
		else $error("nack not followed by stop");
	AST_REP_START: assert property ((s_ack_done and !bif.rbit && r.ph == P_REG && !r.wr) |=> r.st == M_START && r.ph == P_ADDR_R) // (R12)
		else $error("read without repeated start");
	AST_LAST_NACK: assert property ((r.st == M_TXACK && bif.cmd_valid) |-> bif.wbit == (r.left == 8'h1)) // (R14)
		else $error("master ack level wrong");
	AST_INT_CONT: assert property ((!r.int_v && r.low_cnt == INT_LONG_CYC) |=> r.short_on || r.int_v) // (R17)
		else $error("held alert not flagged");
	AST_INT_PULSE: assert property (r.int_evt |-> $past(r.int_v) && !$past(r.int_v, 2) && !r.short_on) // (R15)
		else $error("pulse event without pulse");
	AST_STOP_END: assert property ((r.st == M_STOP && bif.done) |=> r.xdone ##1 !r.xdone) // (R23)
		else $error("done pulse wrong");
endmodule : charger_host
`default_nettype wire

// ==== verification/charger_model.sv ====
/*
 Behavioural charger target: register file, burst access, status flags, alert pin.
 Assumes the bench resolves the open-drain lines and calls set_flags.
*/
`timescale 1ns/1ns
`default_nettype none
`include "chg_map.svh"
module charger_model #(
	parameter int PULSE_NS = 1000000
) (
	input wire logic scl,
	input wire logic sda,
	output var logic scl_lo,
	output var logic sda_lo,
	output var logic int_n,
	output var logic plus_src,
	output var logic minus_src,
	output var logic joined,
	output var int plus_mv,
	output var int minus_mv
);
	logic [7:0] regs [16];
	logic [7:0] sh, tx, ptr, flags, latch;
	logic rd, mack;
	int st, n, left, stretch_ns;
	initial begin
		{scl_lo, sda_lo, rd, mack, flags, latch, ptr} = '0;
		int_n = 1;
		{st, n, left, stretch_ns} = '0;
		foreach (regs[i]) regs[i] = 8'h00;
	end
	// ---
	// Bus side
	// ---
	// start on fall, stop on rise
	always @(sda) begin
		if (scl) begin
			st = sda ? 0 : 1;
			n = 0;
			sda_lo = 0;
		end
	end
	always @(posedge scl) begin
		if (n < 8)
			sh = {sh[6:0], sda};
		else
			mack = sda;
		n = n + 1;
	end
	always @(negedge scl) begin
		if (st != 0 && n == 8) begin
			if (st == 1) begin
				rd = sh[0];
				st = (sh[7:1] == 7'h74) ? 1 : 0;
			end
			if (st == 2)
				st = (sh < 8'h10) ? 2 : 0;
			ptr = (st == 2) ? sh : ptr;
			if (st == 3) begin
				regs[ptr[3:0]] = sh;
				ptr = ptr + 1;
			end
			sda_lo = st inside {1, 2, 3};
		end else if (st != 0 && n == 9) begin
			n = 0;
			sda_lo = 0;
			// phase order, master nack ends read
			if (st == 4 && mack)
				st = 0;
			else if (st == 1)
				st = rd ? 4 : 2;
			else if (st == 2)
				st = 3;
			if (st == 4) begin
				tx = (ptr == 9) ? {1'b0, latch[6:5], flags[4:0]} : regs[ptr[3:0]];
				latch = (ptr == 9) ? 8'h00 : latch;
				ptr = ptr + 1;
				sda_lo = !tx[7];
			end
			scl_lo = stretch_ns > 0;
			#(stretch_ns);
			scl_lo = 0;
		end else if (st == 4 && n > 0 && n < 8)
			sda_lo = !tx[7 - n];
	end
	// ---
	// Line control and alert
	// ---
	function automatic int volts(input logic [1:0] c);
		return (c == `VSEL_2V75) ? 2750 : (c == `VSEL_1V2) ? 1200 : 0;
	endfunction : volts
	always_comb begin
		plus_src = regs[12][7:6] == `LINE_SOURCE;
		minus_src = regs[12][5:4] == `LINE_SOURCE;
		plus_mv = volts(regs[12][3:2]);
		minus_mv = volts(regs[12][1:0]);
		joined = regs[13][0] == `LINES_JOINED;
	end
	task automatic set_flags(input logic [7:0] f);
		logic [7:0] trig;
		trig = ((f ^ flags) & 8'h1b) | (f & ~flags & 8'h60);
		latch = latch | (f & 8'h60);
		flags = f;
		if (|(trig & ~regs[11]))
			left = PULSE_NS;
	endtask : set_flags
	always #1 begin
		left = (left > 0) ? left - 1 : 0;
		int_n = !(left > 0 || (flags[2] && !regs[11][2]));
	end
endmodule : charger_model
`default_nettype wire

// ==== verification/testbench.sv ====
/*
 Self-checking bench for the charger host with a behavioural charger target.
 Assumes the target model and the design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench import chg_pkg::*;;
	logic clk, resetn, req_valid, req_ready, req_write, wdata_valid, wdata_ready, nk;
	logic rdata_valid, xfer_done, xfer_nack, scl_oe, sda_oe, int_event, short_alert;
	logic scl_lo, sda_lo, int_n, plus_src, minus_src, joined;
	logic [7:0] req_reg, req_len, wdata, rdata, flags, latch;
	logic [7:0] ref_regs [16];
	logic [7:0] wq [$];
	logic [7:0] rq [$];
	int plus_mv, minus_mv, err_total, check_count, seed;
	int eb [3] = '{0, 1, 3};
	wire scl_w = !(scl_oe || scl_lo);
	wire sda_w = !(sda_oe || sda_lo);
	initial clk = 0;
	always #2 clk = !clk;
	charger_host #(.INT_LONG_CYC(20'd200)) DUT (.clk(clk), .resetn(resetn), .fast_mode(1'b1),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_reg(req_reg),
		.req_len(req_len), .wdata(wdata), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready),
		.rdata(rdata), .rdata_valid(rdata_valid), .xfer_done(xfer_done), .xfer_nack(xfer_nack),
		.scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
		.int_n_in(int_n), .int_event(int_event), .short_alert(short_alert));
	charger_model #(.PULSE_NS(200)) far_end (.scl(scl_w), .sda(sda_w), .scl_lo(scl_lo),
		.sda_lo(sda_lo), .int_n(int_n), .plus_src(plus_src), .minus_src(minus_src),
		.joined(joined), .plus_mv(plus_mv), .minus_mv(minus_mv));
	// ---
	// Checking and closing
	// ---
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// One user transfer; bytes fed from wq, read bytes gathered in rq
	task automatic xfer(input logic wr, input logic [7:0] ra, input int n);
		int k, c;
		logic took;
		k = 0;
		took = 0;
		rq = {};
		req_write = wr;
		req_reg = ra;
		req_len = 8'(n);
		req_valid = 1;
		wdata = wq[0];
		wdata_valid = wr;
		for (c = 0; c < 80000; c++) begin
			@(negedge clk);
			req_valid = 0;
			if (took) begin
				k++;
				wdata = (k < n) ? wq[k] : 8'h00;
				wdata_valid = wr && k < n;
			end
			took = wdata_valid && wdata_ready;
			if (rdata_valid)
				rq.push_back(rdata);
			if (xfer_done)
				break;
		end
		nk = xfer_nack;
		wdata_valid = 0;
		if (c == 80000) begin
			err_total++;
			end_sim();
		end
	endtask : xfer
	// Flag change in the target, then look for an alert pulse
	task automatic flag(input int b, input logic v, input logic exp);
		logic seen;
		flags[b] = v;
		latch = latch | (flags & 8'h60);
		far_end.set_flags(flags);
		seen = 0;
		repeat (120) begin
			@(negedge clk);
			seen = seen | int_event;
		end
		check(seen, exp);
	endtask : flag
	// ---
	// Main sequence
	// ---
	initial begin
		{seed, err_total, check_count} = '0;
		seed = 32'h4e31;
		{resetn, req_valid, req_write, req_reg, req_len, wdata, wdata_valid, flags, latch} = '0;
		foreach (ref_regs[i]) ref_regs[i] = 8'h00;
		repeat (16) @(negedge clk);
		resetn = 1;
		// Burst: mask charge-done, drive config A, lines apart
		wq = {8'h10, 8'h5a, 8'h00};
		for (int i = 0; i < 3; i++) ref_regs[11 + i] = wq[i];
		xfer(1, 8'h0b, 3);
		check(nk, 0);
		check(req_ready, 1);
		check({plus_src, minus_src}, 2'b11);
		check(plus_mv, 2750);
		check(minus_mv, 2750);
		check(joined, 0);
		// Alert edges per flag kind
		foreach (eb[i]) begin
			flag(eb[i], 1, 1);
			flag(eb[i], 0, 1);
		end
		flag(5, 1, 1);
		flag(5, 0, 0);
		flag(6, 1, 1);
		flag(4, 1, 0);
		flag(2, 1, 0);
		repeat (150) @(negedge clk);
		check(short_alert, 1);
		flag(2, 0, 0);
		check(short_alert, 0);
		// Status read returns, then clears, latched bits
		xfer(0, 8'h09, 1);
		check(rq[0], {1'b0, latch[6:5], flags[4:0]});
		latch = 8'h00;
		// Config B with a stretching target, random voltage bits on the floating line
		far_end.stretch_ns = 3000;
		wq = {8'h11 | (8'($random(seed)) & 8'h0c), 8'h01};
		ref_regs[12] = wq[0];
		ref_regs[13] = wq[1];
		xfer(1, 8'h0c, 2);
		check(nk, 0);
		check({plus_src, minus_src}, 2'b01);
		check(minus_mv, 1200);
		check(joined, 1);
		far_end.stretch_ns = 0;
		// Burst read back over status and control
		xfer(0, 8'h09, 5);
		check(rq.size(), 5);
		check(rq[0], {1'b0, latch[6:5], flags[4:0]});
		for (int i = 1; i < 5; i++) check(rq[i], ref_regs[9 + i]);
		// Unmapped register address
		wq = {8'h33};
		xfer(1, 8'h40, 1);
		check(nk, 1);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
